/* File: cmu_pkg.sv */
// constants, operation codes and register map of the central math unit
package cmu_pkg;

   // ==========================================================
   // sequencer operations
   typedef enum logic [4:0] {
      CMU_OP_NOP,
      CMU_OP_LOAD_ACC,
      CMU_OP_ADD,
      CMU_OP_SUB,
      CMU_OP_ADD_ULOW,
      CMU_OP_SUB_ULOW,
      CMU_OP_XOR,
      CMU_OP_AND,
      CMU_OP_OR,
      CMU_OP_STORE_HIGH,
      CMU_OP_STORE_LOW,
      CMU_OP_SET_SAT,
      CMU_OP_CLR_SAT,
      CMU_OP_BRANCH_OV,
      CMU_OP_LOAD_STATUS,
      CMU_OP_STORE_STATUS,
      CMU_OP_LOAD_OPERAND,
      CMU_OP_LOAD_OPERAND_ADD,
      CMU_OP_MULTIPLY,
      CMU_OP_MULTIPLY_IMM,
      CMU_OP_PROD_TO_ACC,
      CMU_OP_ADD_PROD,
      CMU_OP_SUB_PROD
   } cmu_op_t;

   // ==========================================================
   // datapath constants
   localparam int CMU_DATA_W = 16;
   localparam int CMU_ACC_W = 32;
   localparam int CMU_IMM_W = 13;
   localparam logic [4:0] CMU_IN_SHIFT_MAX = 5'h10;
   localparam logic [4:0] CMU_OUT_SHIFT_1 = 5'h01;
   localparam logic [4:0] CMU_OUT_SHIFT_4 = 5'h04;
   localparam logic [31:0] CMU_SAT_POS = 32'h7fffffff;
   localparam logic [31:0] CMU_SAT_NEG = 32'h80000000;
   localparam logic [31:0] CMU_ACC_RST = 32'h00000000;
   localparam logic [31:0] CMU_PROD_RST = 32'h00000000;
   localparam logic [15:0] CMU_OPND_RST = 16'h0000;

   // ==========================================================
   // status word layout for load/store status
   localparam int CMU_ST_OV_BIT = 15;
   localparam int CMU_ST_SAT_BIT = 14;
   localparam logic [13:0] CMU_ST_FILL = 14'h0000;

   // ==========================================================
   // apb register map (byte addresses)
   localparam int CMU_ADDR_W = 8;
   localparam logic [7:0] CMU_REG_CTRL = 8'h00;
   localparam logic [7:0] CMU_REG_STATUS = 8'h04;
   localparam logic [7:0] CMU_REG_ACC = 8'h08;
   localparam logic [7:0] CMU_REG_PROD = 8'h0c;
   localparam logic [7:0] CMU_REG_OPND = 8'h10;
   localparam int CMU_CTRL_SAT_BIT = 0;
   localparam int CMU_STAT_OV_BIT = 0;
   localparam int CMU_STAT_SAT_BIT = 1;
   localparam int CMU_STAT_INTBLK_BIT = 2;

endpackage

/* File: cmu_central_math_unit.sv */
// central math unit: shifters, alu, accumulator, multiplier, apb registers
// Operation
// - load/add/sub memory word shifted left zero to sixteen places
// - shifter zero-fills low bits, sign-extends above operand to 32 bits
// - unsigned-low add/sub use memory word zero-extended, no sign extension
// - one alu operand is accumulator, other product or input shifter
// - store-high shifts accumulator copy by 0, 1 or 4, stores upper half
// - store-high shift brings low-word bits in, drops bits at top
// - output shift only on data bus path; accumulator unchanged
// - logical ops: memory with low half, zero with high half
// - accumulator stored as high and low words by separate operations
// - saturation on: overflow loads 7fffffff or 80000000
// - saturation off: overflowing result wraps unmodified
// - logical operations never overflow nor saturate
// - any overflow sets sticky overflow flag regardless of saturation
// - overflow flag clears only by branch-on-overflow or status load
// - accumulator condition outputs supplied for conditional branches
// - signed 16x16 product into 32 bits in one cycle
// - 16-bit operand register from bus; 32-bit product per multiply
// - immediate multiply: 13-bit constant, right-justified, sign-extended
// - 8000h times 8000h gives c0000000h, no special handling
// - after multiply, interrupts blocked until next instruction completes
// - product loaded, added or subtracted into accumulator, operand-add
//
// Design decisions made here: the placing of the registers and register access over APB.
module cmu_central_math_unit
   import cmu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CMU_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic op_valid,
   input wire cmu_op_t op_code,
   input wire logic [4:0] shift_amt,
   input wire logic [CMU_DATA_W-1:0] data_in,
   input wire logic [CMU_IMM_W-1:0] imm_value,
   output logic [CMU_DATA_W-1:0] data_out,
   output logic data_out_valid,
   output logic overflow_flag,
   output logic saturation_mode_bit,
   output logic branch_ov_taken,
   output logic int_block,
   output logic acc_lt_zero,
   output logic acc_le_zero,
   output logic acc_ge_zero,
   output logic acc_gt_zero,
   output logic acc_nonzero,
   output logic acc_zero
);

   // ==========================================================
   // state
   logic [31:0] main_accumulator_reg;
   logic [31:0] product_reg;
   logic [15:0] operand_reg;
   logic [31:0] acc_next;
   logic acc_load;
   logic ov_event;
   logic [4:0] in_shift;
   logic [31:0] in_ext;
   logic [31:0] in_shifted;
   logic [31:0] in_unsigned;
   logic [31:0] alu_b;
   logic [31:0] sum;
   logic [31:0] diff;
   logic [31:0] arith_res;
   logic arith_ov;
   logic is_sub;
   logic [31:0] out_shifted;
   logic [15:0] mul_b;
   logic signed [31:0] mul_raw;
   logic [31:0] mul_prod;
   logic apb_done;
   logic apb_wr;
   logic ctrl_wr;
   logic run;

   assign run = op_valid;
   assign apb_done = psel & penable & pready;
   assign apb_wr = apb_done & pwrite;
   assign ctrl_wr = apb_wr & (paddr == CMU_REG_CTRL);

   // ==========================================================
   // input shifter
   always_comb begin
      in_shift = (shift_amt > CMU_IN_SHIFT_MAX) ? CMU_IN_SHIFT_MAX
                                                : shift_amt;
      in_ext = {{16{data_in[15]}}, data_in};
      in_shifted = in_ext << in_shift;
      in_unsigned = {16'h0000, data_in};
   end

   // ==========================================================
   // output shifter, bus path only
   always_comb begin
      if (shift_amt == CMU_OUT_SHIFT_1) begin
         out_shifted = main_accumulator_reg << 1;
      end else if (shift_amt == CMU_OUT_SHIFT_4) begin
         out_shifted = main_accumulator_reg << 4;
      end else begin
         out_shifted = main_accumulator_reg;
      end
   end

   // ==========================================================
   // multiplier
   always_comb begin
      if (op_code == CMU_OP_MULTIPLY_IMM) begin
         mul_b = {{3{imm_value[12]}}, imm_value};
      end else begin
         mul_b = data_in;
      end
      mul_raw = $signed(operand_reg) * $signed(mul_b);
      // 31-bit product sign-extended, so 8000h squared reads c0000000h
      mul_prod = {mul_raw[30], mul_raw[30:0]};
   end

   // ==========================================================
   // alu
   always_comb begin
      is_sub = 1'b0;
      alu_b = in_shifted;
      case (op_code)
         CMU_OP_ADD: alu_b = in_shifted;
         CMU_OP_SUB: begin
            alu_b = in_shifted;
            is_sub = 1'b1;
         end
         CMU_OP_ADD_ULOW: alu_b = in_unsigned;
         CMU_OP_SUB_ULOW: begin
            alu_b = in_unsigned;
            is_sub = 1'b1;
         end
         CMU_OP_ADD_PROD: alu_b = product_reg;
         CMU_OP_LOAD_OPERAND_ADD: alu_b = product_reg;
         CMU_OP_SUB_PROD: begin
            alu_b = product_reg;
            is_sub = 1'b1;
         end
         default: alu_b = in_shifted;
      endcase
      sum = main_accumulator_reg + alu_b;
      diff = main_accumulator_reg - alu_b;
      arith_res = is_sub ? diff : sum;
      if (is_sub) begin
         arith_ov = (main_accumulator_reg[31] != alu_b[31]) &&
                    (diff[31] != main_accumulator_reg[31]);
      end else begin
         arith_ov = (main_accumulator_reg[31] == alu_b[31]) &&
                    (sum[31] != main_accumulator_reg[31]);
      end
   end

   // ==========================================================
   // accumulator next value
   always_comb begin
      acc_next = main_accumulator_reg;
      acc_load = 1'b0;
      ov_event = 1'b0;
      if (run) begin
         case (op_code)
            CMU_OP_LOAD_ACC: begin
               acc_next = in_shifted;
               acc_load = 1'b1;
            end
            CMU_OP_ADD, CMU_OP_SUB, CMU_OP_ADD_ULOW, CMU_OP_SUB_ULOW,
            CMU_OP_ADD_PROD, CMU_OP_SUB_PROD,
            CMU_OP_LOAD_OPERAND_ADD: begin
               acc_load = 1'b1;
               ov_event = arith_ov;
               if (arith_ov && saturation_mode_bit) begin
                  acc_next = main_accumulator_reg[31] ? CMU_SAT_NEG
                                                      : CMU_SAT_POS;
               end else begin
                  acc_next = arith_res;
               end
            end
            CMU_OP_XOR: begin
               acc_next = {main_accumulator_reg[31:16],
                           main_accumulator_reg[15:0] ^ data_in};
               acc_load = 1'b1;
            end
            CMU_OP_AND: begin
               acc_next = {16'h0000,
                           main_accumulator_reg[15:0] & data_in};
               acc_load = 1'b1;
            end
            CMU_OP_OR: begin
               acc_next = {main_accumulator_reg[31:16],
                           main_accumulator_reg[15:0] | data_in};
               acc_load = 1'b1;
            end
            CMU_OP_PROD_TO_ACC: begin
               acc_next = product_reg;
               acc_load = 1'b1;
            end
            default: begin
               acc_next = main_accumulator_reg;
               acc_load = 1'b0;
            end
         endcase
      end
   end

   // ==========================================================
   // accumulator and condition outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         main_accumulator_reg <= CMU_ACC_RST;
      end else if (acc_load) begin
         main_accumulator_reg <= acc_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_lt_zero <= 1'b0;
         acc_le_zero <= 1'b1;
         acc_ge_zero <= 1'b1;
         acc_gt_zero <= 1'b0;
         acc_nonzero <= 1'b0;
         acc_zero <= 1'b1;
      end else begin
         acc_lt_zero <= acc_next[31];
         acc_le_zero <= acc_next[31] | (acc_next == 32'h00000000);
         acc_ge_zero <= ~acc_next[31];
         acc_gt_zero <= ~acc_next[31] & (acc_next != 32'h00000000);
         acc_nonzero <= (acc_next != 32'h00000000);
         acc_zero <= (acc_next == 32'h00000000);
      end
   end

   // ==========================================================
   // multiplier registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         operand_reg <= CMU_OPND_RST;
      end else if (run && (op_code == CMU_OP_LOAD_OPERAND ||
                           op_code == CMU_OP_LOAD_OPERAND_ADD)) begin
         operand_reg <= data_in;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         product_reg <= CMU_PROD_RST;
      end else if (run && (op_code == CMU_OP_MULTIPLY ||
                           op_code == CMU_OP_MULTIPLY_IMM)) begin
         product_reg <= mul_prod;
      end
   end

   // interrupt block lasts through the following instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_block <= 1'b0;
      end else if (run) begin
         int_block <= (op_code == CMU_OP_MULTIPLY ||
                       op_code == CMU_OP_MULTIPLY_IMM);
      end
   end

   // ==========================================================
   // status bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         overflow_flag <= 1'b0;
      end else if (ov_event) begin
         overflow_flag <= 1'b1;
      end else if (run && op_code == CMU_OP_BRANCH_OV) begin
         overflow_flag <= 1'b0;
      end else if (run && op_code == CMU_OP_LOAD_STATUS) begin
         overflow_flag <= data_in[CMU_ST_OV_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         saturation_mode_bit <= 1'b0;
      end else if (run && op_code == CMU_OP_SET_SAT) begin
         saturation_mode_bit <= 1'b1;
      end else if (run && op_code == CMU_OP_CLR_SAT) begin
         saturation_mode_bit <= 1'b0;
      end else if (run && op_code == CMU_OP_LOAD_STATUS) begin
         saturation_mode_bit <= data_in[CMU_ST_SAT_BIT];
      end else if (ctrl_wr) begin
         saturation_mode_bit <= pwdata[CMU_CTRL_SAT_BIT];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         branch_ov_taken <= 1'b0;
      end else begin
         branch_ov_taken <= run && (op_code == CMU_OP_BRANCH_OV) &&
                            overflow_flag;
      end
   end

   // ==========================================================
   // data bus output for stores
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         data_out <= 16'h0000;
         data_out_valid <= 1'b0;
      end else begin
         data_out_valid <= 1'b0;
         if (run) begin
            case (op_code)
               CMU_OP_STORE_HIGH: begin
                  data_out <= out_shifted[31:16];
                  data_out_valid <= 1'b1;
               end
               CMU_OP_STORE_LOW: begin
                  data_out <= main_accumulator_reg[15:0];
                  data_out_valid <= 1'b1;
               end
               CMU_OP_STORE_STATUS: begin
                  data_out <= {overflow_flag, saturation_mode_bit,
                               CMU_ST_FILL};
                  data_out_valid <= 1'b1;
               end
               default: begin
                  data_out <= data_out;
               end
            endcase
         end
      end
   end

   // ==========================================================
   // apb slave, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
      end else begin
         pready <= psel & penable & ~pready;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (psel & penable & ~pready) begin
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         case (paddr)
            CMU_REG_CTRL: begin
               prdata[CMU_CTRL_SAT_BIT] <= saturation_mode_bit;
            end
            CMU_REG_STATUS: begin
               prdata[CMU_STAT_OV_BIT] <= overflow_flag;
               prdata[CMU_STAT_SAT_BIT] <= saturation_mode_bit;
               prdata[CMU_STAT_INTBLK_BIT] <= int_block;
            end
            CMU_REG_ACC: prdata <= main_accumulator_reg;
            CMU_REG_PROD: prdata <= product_reg;
            CMU_REG_OPND: prdata <= {16'h0000, operand_reg};
            default: pslverr <= 1'b1;
         endcase
      end else begin
         pslverr <= 1'b0;
      end
   end

endmodule

/* File: cmu_central_math_unit_sva.sv */
// assertion checker bound to the central math unit
module cmu_chk
   import cmu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic op_valid,
   input wire cmu_op_t op_code,
   input wire logic data_out_valid,
   input wire logic overflow_flag,
   input wire logic saturation_mode_bit,
   input wire logic branch_ov_taken,
   input wire logic int_block,
   input wire logic acc_lt_zero,
   input wire logic acc_le_zero,
   input wire logic acc_ge_zero,
   input wire logic acc_gt_zero,
   input wire logic acc_nonzero,
   input wire logic acc_zero
);
   // ==========================================================
   // decoded operations
   logic is_mul;
   logic is_log;
   logic is_st;
   logic is_clr;
   assign is_mul = op_valid && (op_code == CMU_OP_MULTIPLY
      || op_code == CMU_OP_MULTIPLY_IMM);
   assign is_log = op_valid && (op_code == CMU_OP_XOR
      || op_code == CMU_OP_AND || op_code == CMU_OP_OR);
   assign is_st = op_valid && (op_code == CMU_OP_STORE_HIGH
      || op_code == CMU_OP_STORE_LOW || op_code == CMU_OP_STORE_STATUS);
   assign is_clr = op_valid && (op_code == CMU_OP_BRANCH_OV
      || op_code == CMU_OP_LOAD_STATUS);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ==========================================================
   // sequences and assertions
   sequence s_mul;
      is_mul;
   endsequence
   sequence s_branch;
      op_valid && op_code == CMU_OP_BRANCH_OV && overflow_flag;
   endsequence
   a_int_block: assert property (s_mul |=> int_block)
      else $error("interrupt block missing after multiply");
   a_int_hold: assert property (s_mul ##1 !op_valid |=> int_block)
      else $error("interrupt block dropped without an op");
   a_ov_sticky: assert property (
      overflow_flag && !is_clr |=> overflow_flag)
      else $error("overflow flag cleared on its own");
   a_branch_clears: assert property (
      s_branch |=> branch_ov_taken && !overflow_flag)
      else $error("branch on overflow did not clear flag");
   a_branch_quiet: assert property (
      !overflow_flag |=> !branch_ov_taken)
      else $error("branch taken without overflow");
   a_logic_no_ov: assert property (
      is_log && !overflow_flag |=> !overflow_flag)
      else $error("logical op raised overflow");
   a_store_pulse: assert property (data_out_valid == $past(is_st))
      else $error("store strobe not tied to store op");
   a_sat_set: assert property (
      op_valid && op_code == CMU_OP_SET_SAT |=> saturation_mode_bit)
      else $error("saturation bit not set");
   a_cond_sign: assert property (
      acc_zero == !acc_nonzero
      && acc_le_zero == (acc_lt_zero || acc_zero)
      && acc_ge_zero == !acc_lt_zero
      && acc_gt_zero == (acc_ge_zero && !acc_zero))
      else $error("accumulator conditions disagree");
endmodule

bind cmu_central_math_unit cmu_chk u_chk (.pclk(pclk), .presetn(presetn),
   .op_valid(op_valid), .op_code(op_code), .data_out_valid(data_out_valid),
   .overflow_flag(overflow_flag), .saturation_mode_bit(saturation_mode_bit),
   .branch_ov_taken(branch_ov_taken), .int_block(int_block),
   .acc_lt_zero(acc_lt_zero), .acc_le_zero(acc_le_zero),
   .acc_ge_zero(acc_ge_zero), .acc_gt_zero(acc_gt_zero),
   .acc_nonzero(acc_nonzero), .acc_zero(acc_zero));

/* File: cmu_ram_model.sv */
// data ram model that keeps the last word the math unit stores
module cmu_ram_model (
   input wire logic pclk,
   input wire logic [15:0] data_out,
   input wire logic data_out_valid,
   output logic [15:0] last_word
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // each store delivers one whole 16-bit word
   always_ff @(posedge pclk) begin
      if (data_out_valid) begin
         last_word <= data_out;
      end
   end
endmodule

/* File: tb_cmu_central_math_unit.sv */
// testbench for the central math unit
module tb_cmu_central_math_unit import cmu_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic op_valid, data_out_valid, overflow_flag, saturation_mode_bit;
   logic branch_ov_taken, int_block;
   cmu_op_t op_code;
   logic [4:0] shift_amt;
   logic [15:0] data_in, data_out, word;
   logic [12:0] imm_value;
   wire [5:0] conds;
   int failures = 0;
   int n_compared = 0;
   cmu_central_math_unit u_cmu_central_math_unit (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .op_valid(op_valid), .op_code(op_code),
      .shift_amt(shift_amt), .data_in(data_in), .imm_value(imm_value),
      .data_out(data_out), .data_out_valid(data_out_valid),
      .overflow_flag(overflow_flag),
      .saturation_mode_bit(saturation_mode_bit),
      .branch_ov_taken(branch_ov_taken), .int_block(int_block),
      .acc_lt_zero(conds[5]), .acc_le_zero(conds[4]),
      .acc_ge_zero(conds[3]), .acc_gt_zero(conds[2]),
      .acc_nonzero(conds[1]), .acc_zero(conds[0]));
   cmu_ram_model u_cmu_ram_model (.pclk(pclk), .data_out(data_out),
      .data_out_valid(data_out_valid), .last_word(word));
   // ==========================================================
   // shared tasks
   task automatic final_report;
      $display("compared %0d failed %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("BAD t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 8);
      if (n >= 8) begin
         failures++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, x);
   endtask
   task automatic op(input cmu_op_t c, input logic [15:0] d,
      input logic [4:0] s);
      @(posedge pclk);
      op_valid <= 1'b1;
      op_code <= c;
      data_in <= d;
      shift_amt <= s;
   endtask
   task automatic fin;
      @(posedge pclk);
      op_valid <= 1'b0;
      #1;
   endtask
   task automatic setacc;
      op(CMU_OP_LOAD_ACC, 16'ha34b, 5'h10);
      op(CMU_OP_ADD_ULOW, 16'h78cd, 5'h00);
   endtask
   task automatic st(input cmu_op_t c, input logic [4:0] s,
      input logic [15:0] x);
      op(c, 16'h0, s);
      fin();
      @(posedge pclk);
      #1;
      chk(word, x);
   endtask
   // ==========================================================
   // scenarios
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      chk(conds, 32'h19);
      apb(1'b1, CMU_REG_CTRL, 32'h1, r, e);
      #1;
      chk(saturation_mode_bit, 32'h1);
      rd(CMU_REG_STATUS, 32'h2);
      apb(1'b1, CMU_REG_CTRL, 32'h0, r, e);
      apb(1'b0, 8'h20, 32'h0, r, e);
      chk(e, 32'h1);
      chk(r, 32'h0);
   endtask
   task automatic t_shift;
      op(CMU_OP_LOAD_ACC, 16'h8ebc, 5'h08);
      fin();
      rd(CMU_REG_ACC, 32'hff8ebc00);
      op(CMU_OP_LOAD_ACC, 16'h7ebc, 5'h04);
      op(CMU_OP_ADD, 16'h8000, 5'h10);
      fin();
      rd(CMU_REG_ACC, 32'h8007ebc0);
      op(CMU_OP_SUB_ULOW, 16'hffff, 5'h00);
      fin();
      rd(CMU_REG_ACC, 32'h8006ebc1);
   endtask
   task automatic t_store;
      setacc();
      st(CMU_OP_STORE_HIGH, 5'h04, 16'h34b7);
      st(CMU_OP_STORE_HIGH, 5'h01, 16'h4696);
      st(CMU_OP_STORE_HIGH, 5'h00, 16'ha34b);
      st(CMU_OP_STORE_LOW, 5'h00, 16'h78cd);
      rd(CMU_REG_ACC, 32'ha34b78cd);
   endtask
   task automatic t_logic;
      cmu_op_t c[3] = '{CMU_OP_XOR, CMU_OP_AND, CMU_OP_OR};
      logic [31:0] x[3] = '{32'ha34b883d, 32'h000070c0, 32'ha34bf8fd};
      for (int i = 0; i < 3; i++) begin
         setacc();
         op(c[i], 16'hf0f0, 5'h00);
         fin();
         rd(CMU_REG_ACC, x[i]);
         chk(overflow_flag, 32'h0);
      end
   endtask
   task automatic t_sat;
      op(CMU_OP_LOAD_ACC, 16'h7fff, 5'h10);
      op(CMU_OP_ADD, 16'h7fff, 5'h10);
      fin();
      rd(CMU_REG_ACC, 32'hfffe0000);
      chk(overflow_flag, 32'h1);
      op(CMU_OP_BRANCH_OV, 16'h0, 5'h00);
      fin();
      chk(branch_ov_taken, 32'h1);
      chk(overflow_flag, 32'h0);
      op(CMU_OP_SET_SAT, 16'h0, 5'h00);
      op(CMU_OP_LOAD_ACC, 16'h7fff, 5'h10);
      op(CMU_OP_ADD, 16'h7fff, 5'h10);
      fin();
      rd(CMU_REG_ACC, 32'h7fffffff);
      chk(overflow_flag, 32'h1);
      op(CMU_OP_LOAD_ACC, 16'h8000, 5'h10);
      op(CMU_OP_SUB, 16'h7fff, 5'h10);
      fin();
      rd(CMU_REG_ACC, 32'h80000000);
      st(CMU_OP_STORE_STATUS, 5'h00, 16'hc000);
      op(CMU_OP_LOAD_STATUS, 16'h0, 5'h00);
      fin();
      chk({overflow_flag, saturation_mode_bit}, 32'h0);
   endtask
   task automatic t_mult;
      op(CMU_OP_LOAD_OPERAND, 16'h8000, 5'h00);
      imm_value <= 13'h1fff;
      op(CMU_OP_MULTIPLY, 16'h8000, 5'h00);
      fin();
      chk(int_block, 32'h1);
      rd(CMU_REG_PROD, 32'hc0000000);
      op(CMU_OP_PROD_TO_ACC, 16'h0, 5'h00);
      fin();
      chk(int_block, 32'h0);
      chk(conds, 32'h32);
      op(CMU_OP_MULTIPLY_IMM, 16'h0, 5'h00);
      op(CMU_OP_ADD_PROD, 16'h0, 5'h00);
      fin();
      rd(CMU_REG_ACC, 32'hc0008000);
      op(CMU_OP_LOAD_OPERAND_ADD, 16'h0003, 5'h00);
      op(CMU_OP_MULTIPLY, 16'hfffe, 5'h00);
      op(CMU_OP_SUB_PROD, 16'h0, 5'h00);
      fin();
      rd(CMU_REG_ACC, 32'hc0010006);
      rd(CMU_REG_OPND, 32'h3);
      rd(CMU_REG_PROD, 32'hfffffffa);
      op(CMU_OP_LOAD_ACC, 16'h0001, 5'h00);
      fin();
      chk(conds, 32'h0e);
   endtask
   // ==========================================================
   // clock and main sequence
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, op_valid} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      op_code = CMU_OP_NOP;
      shift_amt = 5'h00;
      data_in = 16'h0;
      imm_value = 13'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_shift();
      t_store();
      t_logic();
      t_sat();
      t_mult();
      final_report();
   end
endmodule
